// ==== rtl/tbp_timer.sv ====
// multi-channel 16-bit timer: buffering, cascade, pwm and phase counting
`timescale 1ns/10ps
`include "tbp_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// - buffering only on channels 0, 3, 4; C buffers A, D buffers B
// - buffered compare match copies the buffer into the general register
// - buffered capture loads count, old general value moves to buffer
// - cascade chains channel 1 (upper) and channel 2 (lower) into 32 bits
// - prescale select 111 on channel 1 counts channel 2 wraps
// - upper half counts up on lower overflow, down on lower underflow
// - phase counting on channel 1 overrides its cascade prescale setting
// - every channel does pwm; match drives 0, 1 or toggles
// - pwm mode 1 pairs A/B and C/D onto pin A or C, A/C initial level
// - pwm mode 1 with equal pair values leaves the output unchanged
// - pwm mode 2 returns duty pins to initial level on counter clear
// - pwm mode 2 equal period and duty value leaves output unchanged
// - pwm mode 2 accepted only on channels 0, 1, 2
// - pwm mode 2 period register pin gives no waveform
// - period equal duty keeps the waveform constant, first pulse too
// - phase counting only on channels 1, 2, pins as clock, up/down
// - clear, capture, compare stay functional while phase counting
// - phase overflow up sets overflow flag, underflow down sets underflow
// - status shows the current count direction
// - channel 1 and channel 2 each have their own phase pin pair
// - phase mode 1 steps on every edge, direction from other phase level
//////////////////////////////////////////////////////////////////////////////
module tbp_timer
  import tbp_pkg::*;
#(
  parameter int PSC_W = `TBP_PSC_W
)
(
  // clock and reset
  input  logic        ref_clk,
  input  logic        srst,
  // ahb-lite slave
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  // compare/capture pins, index channel*4 + register
  input  logic [19:0] ioPinIn,
  output logic [19:0] ioPinOut,
  output logic [19:0] ioPinOeN,
  // two-phase clock pins
  input  logic        phaseA1In,
  input  logic        phaseB1In,
  input  logic        phaseA2In,
  input  logic        phaseB2In
);

  localparam int NCH  = `TBP_NCH;
  localparam int NREG = `TBP_NREG;
  localparam int NPIN = NCH * NREG;
  localparam logic [NCH-1:0] BUF_CH = `TBP_BUF_CH;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] phaseStep(input tbp_mode_e md, input logic aNow,
                                           input logic aOld, input logic bNow,
                                           input logic bOld);
    logic aRise, aFall, bRise, bFall, up, dn;
    aRise = aNow & ~aOld;
    aFall = ~aNow & aOld;
    bRise = bNow & ~bOld;
    bFall = ~bNow & bOld;
    case (md)
      TBP_PH1:
      begin
        up = (aNow & bRise) | (~aNow & bFall) | (aRise & ~bNow) | (aFall & bNow);
        dn = (aNow & bFall) | (~aNow & bRise) | (aRise & bNow) | (aFall & ~bNow);
      end
      TBP_PH2:
      begin
        up = aFall & bNow;
        dn = aFall & ~bNow;
      end
      TBP_PH3:
      begin
        up = aFall & bNow;
        dn = aNow & bFall;
      end
      TBP_PH4:
      begin
        up = (aNow & bRise) | (~aNow & bFall);
        dn = (aNow & bFall) | (~aNow & bRise);
      end
      default:
      begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    // in phase mode 1 both phases moving at once is a glitch: cancel rather than guess
    return {up ^ dn, up};
  endfunction : phaseStep

  function automatic logic isPhase(input tbp_mode_e md);
    return (md == TBP_PH1) || (md == TBP_PH2) || (md == TBP_PH3) || (md == TBP_PH4);
  endfunction : isPhase

  function automatic logic applyAct(input logic [1:0] act, input logic cur);
    case (act)
      2'h1:    return 1'b0;
      2'h2:    return 1'b1;
      2'h3:    return ~cur;
      default: return cur;
    endcase
  endfunction : applyAct

  // {valid, index} of the register that clears the counter
  function automatic logic [2:0] clrIndex(input logic [2:0] sel);
    case (sel)
      `TBP_CLR_A: return 3'h4;
      `TBP_CLR_B: return 3'h5;
      `TBP_CLR_C: return 3'h6;
      `TBP_CLR_D: return 3'h7;
      default:    return 3'h0;
    endcase
  endfunction : clrIndex

  function automatic logic pscTick(input logic [2:0] sel, input logic [PSC_W-1:0] psc);
    case (sel)
      3'h0:    return 1'b1;
      // a narrow prescaler saturates at its slowest division
      3'h1:    return &(psc | ~PSC_W'(4'h3));
      3'h2:    return &(psc | ~PSC_W'(4'hf));
      3'h3:    return &psc;
      default: return 1'b0;
    endcase
  endfunction : pscTick

  function automatic logic modeOk(input int ch, input logic [3:0] md);
    logic [NCH-1:0] pwm2Ch, phCh;
    pwm2Ch = `TBP_PWM2_CH;
    phCh   = `TBP_PHASE_CH;
    case (md)
      TBP_NORMAL, TBP_PWM1:             return 1'b1;
      TBP_PWM2:                         return pwm2Ch[ch];
      TBP_PH1, TBP_PH2, TBP_PH3, TBP_PH4: return phCh[ch];
      default:                          return 1'b0;
    endcase
  endfunction : modeOk

  //////////////////////////////////////////////////////////////////////////////
  tbp_ctrl_s        ctrl_q  [NCH];
  tbp_mode_s        mode_q  [NCH];
  logic [15:0]      io_q    [NCH];
  tbp_word_t        cnt_q   [NCH];
  tbp_word_t        tgr_q   [NCH][NREG];
  logic [5:0]       flag_q  [NCH];
  logic [NCH-1:0]   dir_q;
  logic [NCH-1:0]   run_q;
  logic [PSC_W-1:0] psc_q;
  logic [NPIN-1:0]  pinS1_q, pinS2_q, pinS3_q, pinLvl_q;
  logic [3:0]       phS1_q, phS2_q, phS3_q;
  tbp_ahb_s         ap_q;
  logic             apValid_q;
  logic [31:0]      rdata_q;

  logic [1:0]       phStep  [NCH];
  logic [NCH-1:0]   tick, up, ovf, unf, clrEv, cascade, cntWr;
  logic [NREG-1:0]  match   [NCH];
  logic [NREG-1:0]  capt    [NCH];
  logic [2:0]       clrSel  [NCH];
  logic [1:0]       bufOn   [NCH];
  logic             wrHit, apValid;
  logic [2:0]       wrCh;
  logic [5:0]       wrOff;
  logic [31:0]      rdVal;

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  assign apValid   = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign wrHit     = apValid_q & ap_q.wr;
  assign wrCh      = ap_q.addr[`TBP_CH_MSB:`TBP_CH_LSB];
  assign wrOff     = ap_q.addr[`TBP_CH_LSB-1:0];

  always_comb
  begin
    logic [2:0] ch;
    logic [5:0] off;
    ch    = haddr[`TBP_CH_MSB:`TBP_CH_LSB];
    off   = haddr[`TBP_CH_LSB-1:0];
    rdVal = 32'h0000_0000;
    if (haddr[`TBP_ADDR_MSB:`TBP_CH_MSB+1] != '0)
      rdVal = 32'h0000_0000;
    else if (haddr[`TBP_CH_MSB:0] == `TBP_OFF_START)
      rdVal = {27'h0, run_q};
    else if (ch < 3'(NCH))
    begin
      case (off)
        `TBP_OFF_CTRL:  rdVal = {24'h0, ctrl_q[ch]};
        `TBP_OFF_MODE:  rdVal = {26'h0, mode_q[ch]};
        `TBP_OFF_IOCTL: rdVal = {16'h0, io_q[ch]};
        `TBP_OFF_STAT:  rdVal = {24'h0, dir_q[ch], 1'b0, flag_q[ch]};
        `TBP_OFF_COUNT: rdVal = {16'h0, cnt_q[ch]};
        default:
        begin
          if (off >= `TBP_OFF_GRA && off <= `TBP_OFF_GRD && off[1:0] == 2'h0)
            rdVal = {16'h0, tgr_q[ch][2'((off - `TBP_OFF_GRA) >> 2)]};
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ap_q      <= '0;
      apValid_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      apValid_q <= apValid;
      if (apValid)
        ap_q <= '{wr: hwrite, addr: haddr[`TBP_CH_MSB:0]};
      if (apValid && !hwrite)
        rdata_q <= rdVal;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration and start registers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      run_q <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        ctrl_q[c] <= '0;
        mode_q[c] <= '{bufB: 1'b0, bufA: 1'b0, mode: TBP_NORMAL};
        io_q[c]   <= 16'h0000;
      end
    end
    else if (wrHit)
    begin
      if (ap_q.addr == `TBP_OFF_START)
        run_q <= hwdata[NCH-1:0];
      for (int c = 0; c < NCH; c++)
      begin
        if (wrCh == 3'(c) && wrOff == `TBP_OFF_CTRL)
          ctrl_q[c] <= hwdata[7:0];
        if (wrCh == 3'(c) && wrOff == `TBP_OFF_IOCTL)
          io_q[c] <= hwdata[15:0];
        // an illegal mode for the channel is dropped, the old one stays
        if (wrCh == 3'(c) && wrOff == `TBP_OFF_MODE && modeOk(c, hwdata[3:0]))
        begin
          mode_q[c].mode <= tbp_mode_e'(hwdata[3:0]);
          mode_q[c].bufA <= hwdata[4] & BUF_CH[c];
          mode_q[c].bufB <= hwdata[5] & BUF_CH[c];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // count sources, compare and capture events
  always_comb
  begin
    for (int c = NCH - 1; c >= 0; c--)
    begin
      phStep[c] = 2'b00;
      if (c == 1)
        phStep[c] = phaseStep(mode_q[c].mode, phS2_q[0], phS3_q[0], phS2_q[1], phS3_q[1]);
      if (c == 2)
        phStep[c] = phaseStep(mode_q[c].mode, phS2_q[2], phS3_q[2], phS2_q[3], phS3_q[3]);
      cascade[c] = (c == 1) && (ctrl_q[c].pscSel == `TBP_PSC_CASCADE)
                   && !isPhase(mode_q[c].mode);
      if (isPhase(mode_q[c].mode))
      begin
        tick[c] = phStep[c][1];
        up[c]   = phStep[c][0];
      end
      else if (cascade[c])
      begin
        tick[c] = ovf[2] | unf[2];
        up[c]   = ovf[2];
      end
      else
      begin
        tick[c] = pscTick(ctrl_q[c].pscSel, psc_q);
        up[c]   = 1'b1;
      end
      tick[c]  = tick[c] & run_q[c];
      ovf[c]   = tick[c] & up[c] & (cnt_q[c] == `TBP_CNT_MAX);
      unf[c]   = tick[c] & ~up[c] & (cnt_q[c] == `TBP_CNT_ZERO);
      bufOn[c] = {mode_q[c].bufB, mode_q[c].bufA};
      clrSel[c] = clrIndex(ctrl_q[c].clrSel);
      cntWr[c] = wrHit && wrCh == 3'(c) && wrOff == `TBP_OFF_COUNT;
      for (int r = 0; r < NREG; r++)
      begin
        logic isCap, slot, rise, fall;
        isCap = io_q[c][4*r + `TBP_IO_CAP];
        slot  = (r >= 2) && bufOn[c][r % 2];
        rise  = pinS2_q[c*NREG + r] & ~pinS3_q[c*NREG + r];
        fall  = ~pinS2_q[c*NREG + r] & pinS3_q[c*NREG + r];
        // match and capture ignore the mode, so phase counting keeps them
        match[c][r] = tick[c] & ~isCap & ~slot & (cnt_q[c] == tgr_q[c][r]);
        case (io_q[c][4*r +: 2])
          2'h0:    capt[c][r] = isCap & ~slot & rise;
          2'h1:    capt[c][r] = isCap & ~slot & fall;
          default: capt[c][r] = isCap & ~slot & (rise | fall);
        endcase
      end
      clrEv[c] = clrSel[c][2] & run_q[c] & (match[c][clrSel[c][1:0]] | capt[c][clrSel[c][1:0]]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // prescaler, counters and direction
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      psc_q <= '0;
      dir_q <= '0;
      for (int c = 0; c < NCH; c++)
        cnt_q[c] <= `TBP_CNT_ZERO;
    end
    else
    begin
      psc_q <= psc_q + 1'b1;
      for (int c = 0; c < NCH; c++)
      begin
        if (tick[c])
          dir_q[c] <= up[c];
        // a software write beats a count in the same cycle
        if (cntWr[c])
          cnt_q[c] <= hwdata[15:0];
        else if (clrEv[c])
          cnt_q[c] <= `TBP_CNT_ZERO;
        else if (tick[c])
          cnt_q[c] <= up[c] ? cnt_q[c] + `TBP_CNT_ONE : cnt_q[c] - `TBP_CNT_ONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general and buffer registers; hardware transfers beat software writes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int c = 0; c < NCH; c++)
        for (int r = 0; r < NREG; r++)
          tgr_q[c][r] <= 16'hffff;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        for (int r = 0; r < NREG; r++)
        begin
          if (wrHit && wrCh == 3'(c) && wrOff == 6'(`TBP_OFF_GRA + 4 * r))
            tgr_q[c][r] <= hwdata[15:0];
          if (capt[c][r])
            tgr_q[c][r] <= cnt_q[c];
        end
        for (int p = 0; p < 2; p++)
        begin
          if (bufOn[c][p] && capt[c][p])
            tgr_q[c][p + 2] <= tgr_q[c][p];
          else if (bufOn[c][p] && match[c][p])
            tgr_q[c][p] <= tgr_q[c][p + 2];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags: write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int c = 0; c < NCH; c++)
        flag_q[c] <= 6'h00;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        logic [5:0] clr;
        clr = (wrHit && wrCh == 3'(c) && wrOff == `TBP_OFF_STAT) ? hwdata[5:0] : 6'h00;
        flag_q[c] <= (flag_q[c] & ~clr)
                     | {unf[c], ovf[c], match[c] | capt[c]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and output levels
  assign ioPinOut = pinLvl_q;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      for (int r = 0; r < NREG; r++)
        ioPinOeN[c*NREG + r] = io_q[c][4*r + `TBP_IO_CAP];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
      phS1_q  <= 4'h0;
      phS2_q  <= 4'h0;
      phS3_q  <= 4'h0;
    end
    else
    begin
      pinS1_q <= ioPinIn;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      phS1_q  <= {phaseB2In, phaseA2In, phaseB1In, phaseA1In};
      phS2_q  <= phS1_q;
      phS3_q  <= phS2_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      pinLvl_q <= '0;
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        for (int r = 0; r < NREG; r++)
        begin
          if (!run_q[c])
            pinLvl_q[c*NREG + r] <= io_q[c][4*r + `TBP_IO_INIT];
          else
          begin
            case (mode_q[c].mode)
              TBP_PWM1:
              begin
                // odd registers only steer the even pin of their pair
                if (r % 2 == 1)
                  pinLvl_q[c*NREG + r] <= io_q[c][4*r + `TBP_IO_INIT];
                // r | 1 keeps the unrolled odd lanes inside the arrays
                else if (tgr_q[c][r] == tgr_q[c][r | 1])
                  pinLvl_q[c*NREG + r] <= pinLvl_q[c*NREG + r];
                else if (match[c][r])
                  pinLvl_q[c*NREG + r] <= applyAct(io_q[c][4*r +: 2],
                                                   pinLvl_q[c*NREG + r]);
                else if (match[c][r | 1])
                  pinLvl_q[c*NREG + r] <= applyAct(io_q[c][4*(r | 1) +: 2],
                                                   pinLvl_q[c*NREG + r]);
              end
              TBP_PWM2:
              begin
                if (!clrSel[c][2] || clrSel[c][1:0] == 2'(r))
                  pinLvl_q[c*NREG + r] <= io_q[c][4*r + `TBP_IO_INIT];
                else if (clrEv[c])
                  pinLvl_q[c*NREG + r] <= io_q[c][4*r + `TBP_IO_INIT];
                else if (match[c][r] && tgr_q[c][r] != tgr_q[c][clrSel[c][1:0]])
                  pinLvl_q[c*NREG + r] <= applyAct(io_q[c][4*r +: 2],
                                                   pinLvl_q[c*NREG + r]);
              end
              default:
              begin
                if (match[c][r])
                  pinLvl_q[c*NREG + r] <= applyAct(io_q[c][4*r +: 2],
                                                   pinLvl_q[c*NREG + r]);
              end
            endcase
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cbChk @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence seqCascadeStep;
    cascade[1] && !clrEv[1] && !cntWr[1];
  endsequence

  chk_buf_cmp_copy: assert property (
    bufOn[0][0] && match[0][0] && !capt[0][0] |=> tgr_q[0][0] == $past(tgr_q[0][2]))
    else $error("buffered compare did not copy buffer C into A");

  chk_buf_cap_shift: assert property (
    bufOn[3][1] && capt[3][1] |=> tgr_q[3][1] == $past(cnt_q[3]) && tgr_q[3][3] == $past(tgr_q[3][1]))
    else $error("buffered capture did not shift B into D");

  chk_buf_channels: assert property (
    bufOn[1] == 2'b00 && bufOn[2] == 2'b00)
    else $error("buffering enabled on a channel without buffers");

  chk_cascade_up: assert property (
    seqCascadeStep and ovf[2] && run_q[1] |=> cnt_q[1] == $past(cnt_q[1]) + `TBP_CNT_ONE)
    else $error("upper half missed a lower overflow");

  chk_cascade_down: assert property (
    seqCascadeStep and unf[2] && run_q[1] |=> cnt_q[1] == $past(cnt_q[1]) - `TBP_CNT_ONE)
    else $error("upper half missed a lower underflow");

  chk_phase_source: assert property (
    isPhase(mode_q[1].mode) && run_q[1] |-> tick[1] == phStep[1][1] && !cascade[1])
    else $error("phase channel counted from another source");

  chk_pwm2_reject: assert property (
    mode_q[3].mode != TBP_PWM2 && mode_q[4].mode != TBP_PWM2)
    else $error("pwm mode 2 accepted on channel 3 or 4");

  chk_pwm1_equal_hold: assert property (
    run_q[0] && mode_q[0].mode == TBP_PWM1 && tgr_q[0][0] == tgr_q[0][1]
    |=> $stable(ioPinOut[0]))
    else $error("pwm mode 1 output moved with equal pair");

  chk_pwm2_clear_init: assert property (
    run_q[0] && mode_q[0].mode == TBP_PWM2 && clrEv[0] && clrSel[0][1:0] != 2'h0
    |=> ioPinOut[0] == $past(io_q[0][`TBP_IO_INIT]))
    else $error("pwm mode 2 pin not at initial level after clear");

  chk_dir_flag: assert property (
    tick[2] |=> dir_q[2] == $past(up[2]) ##1 (dir_q[2] == $past(dir_q[2]) || $past(tick[2])))
    else $error("direction flag does not follow the count");

  chk_ovf_flag: assert property (
    ovf[1] ##1 !(cntWr[1]) |-> flag_q[1][`TBP_ST_OVF])
    else $error("overflow flag not set");

endmodule : tbp_timer

// ==== rtl/tbp_params.svh ====
// register map, field positions and constants of the multi-channel timer
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH

`define TBP_NCH         5
`define TBP_NREG        4
`define TBP_PSC_W       6
`define TBP_CH_LSB      6
`define TBP_CH_MSB      8
`define TBP_ADDR_MSB    31
`define TBP_OFF_CTRL    6'h00
`define TBP_OFF_MODE    6'h04
`define TBP_OFF_IOCTL   6'h08
`define TBP_OFF_STAT    6'h0c
`define TBP_OFF_COUNT   6'h10
`define TBP_OFF_GRA     6'h14
`define TBP_OFF_GRD     6'h20
`define TBP_OFF_START   9'h140
`define TBP_PSC_CASCADE 3'h7
`define TBP_CLR_A       3'h1
`define TBP_CLR_B       3'h2
`define TBP_CLR_C       3'h5
`define TBP_CLR_D       3'h6
`define TBP_IO_INIT     2
`define TBP_IO_CAP      3
`define TBP_ST_OVF      4
`define TBP_ST_UNF      5
`define TBP_BUF_CH      5'h19
`define TBP_PHASE_CH    5'h06
`define TBP_PWM2_CH     5'h07
`define TBP_CNT_MAX     16'hffff
`define TBP_CNT_ZERO    16'h0000
`define TBP_CNT_ONE     16'h0001

`endif

// ==== rtl/tbp_pkg.sv ====
// types shared by the multi-channel timer
package tbp_pkg;

  typedef logic [15:0] tbp_word_t;

  typedef enum logic [3:0] {
    TBP_NORMAL = 4'b0000,
    TBP_PWM1   = 4'b0010,
    TBP_PWM2   = 4'b0011,
    TBP_PH1    = 4'b0100,
    TBP_PH2    = 4'b0101,
    TBP_PH3    = 4'b0110,
    TBP_PH4    = 4'b0111
  } tbp_mode_e;

  typedef struct packed {
    logic [2:0] clrSel;
    logic [1:0] edgeSel;
    logic [2:0] pscSel;
  } tbp_ctrl_s;

  typedef struct packed {
    logic      bufB;
    logic      bufA;
    tbp_mode_e mode;
  } tbp_mode_s;

  typedef struct packed {
    logic       wr;
    logic [8:0] addr;
  } tbp_ahb_s;

endpackage : tbp_pkg

// ==== sim/tbp_encoder.sv ====
// quadrature encoder model driving both phase pin pairs
`timescale 1ns/10ps
module tbp_encoder (
  // clock
  input  wire logic ref_clk,
  // phase pins
  output logic      phaseA1,
  output logic      phaseB1,
  output logic      phaseA2,
  output logic      phaseB2
);
  logic [1:0] idx1 = 2'h0;
  logic [1:0] idx2 = 2'h0;
  // gray order 00,10,11,01: exactly one pin changes per step
  function automatic logic [1:0] ab(input logic [1:0] i);
    return (i == 2'h0) ? 2'h0 : (i == 2'h1) ? 2'h2 : (i == 2'h2) ? 2'h3 : 2'h1;
  endfunction : ab
  assign {phaseA1, phaseB1} = ab(idx1);
  assign {phaseA2, phaseB2} = ab(idx2);
  // level held 4 clocks, the synchroniser needs 3
  task automatic step(input int ch, input logic up);
    if (ch == 1)
      idx1 <= up ? idx1 + 2'h1 : idx1 - 2'h1;
    else
      idx2 <= up ? idx2 + 2'h1 : idx2 - 2'h1;
    repeat (4) @(posedge ref_clk);
  endtask : step
endmodule : tbp_encoder

// ==== sim/test_timer_buffer_cascade_pwm_phase.sv ====
// self-checking bench of the multi-channel timer
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_timer_buffer_cascade_pwm_phase;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic [19:0] ioPinOut;
  logic [19:0] ioPinOeN;
  logic [19:0] ioPinIn = 20'h0;
  logic        pA1, pB1, pA2, pB2;
  int          err_count = 0;
  int          check_count = 0;
  tbp_timer #(.PSC_W(2)) i_tbp_timer (.ref_clk(ref_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOeN(ioPinOeN), .phaseA1In(pA1),
    .phaseB1In(pB1), .phaseA2In(pA2), .phaseB2In(pB2));
  tbp_encoder i_tbp_encoder (.ref_clk(ref_clk), .phaseA1(pA1), .phaseB1(pB1),
    .phaseA2(pA2), .phaseB2(pB2));
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // bounded wait for hready sampled high at a rising edge
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        err_count++;
        complete_run();
      end
      @(posedge ref_clk);
    end
  endtask : waitRdy
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask : rdChk
  task automatic doReset();
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask : doReset
  // high samples of one pin over eight settled cycles, taken at the falling edge
  task automatic cntHigh(input int p, output int n);
    n = 0;
    repeat (8) @(posedge ref_clk);
    repeat (8)
    begin
      @(negedge ref_clk);
      n += ioPinOut[p];
    end
    @(posedge ref_clk);
  endtask : cntHigh
  //////////////////////////////////////////////////////////////////////////////
  task automatic testRefuse();
    doReset();
    rdChk(32'h14, 32'hffff, 32'hffff);
    rdChk(32'h150, 32'hffffffff, 32'h0);
    wr(32'hc4, 32'h3);
    rdChk(32'hc4, 32'hf, 32'h0);
    wr(32'h04, 32'h4);
    rdChk(32'h04, 32'hf, 32'h0);
    wr(32'h64, 32'h10);
    rdChk(32'h64, 32'h10, 32'h0);
    wr(32'hc4, 32'h2);
    rdChk(32'hc4, 32'hf, 32'h2);
    $display("test refuse done");
  endtask : testRefuse
  task automatic testBuffer();
    doReset();
    wr(32'h14, 32'h3);
    wr(32'h1c, 32'h5);
    wr(32'h00, 32'h20);
    wr(32'h08, 32'h3);
    wr(32'h04, 32'h10);
    wr(32'h140, 32'h1);
    repeat (20) @(posedge ref_clk);
    rdChk(32'h14, 32'hffff, 32'h5);
    $display("test buffer done");
  endtask : testBuffer
  task automatic testPhase();
    doReset();
    wr(32'h40, 32'h7);
    wr(32'h44, 32'h4);
    wr(32'h140, 32'h2);
    repeat (4) i_tbp_encoder.step(1, 1'b1);
    rdChk(32'h50, 32'hffff, 32'h4);
    rdChk(32'h4c, 32'h80, 32'h80);
    repeat (5) i_tbp_encoder.step(1, 1'b0);
    rdChk(32'h50, 32'hffff, 32'hffff);
    rdChk(32'h4c, 32'hb0, 32'h20);
    $display("test phase done");
  endtask : testPhase
  task automatic testCascade();
    doReset();
    wr(32'h40, 32'h7);
    wr(32'h84, 32'h4);
    wr(32'h90, 32'hffff);
    wr(32'h50, 32'hffff);
    wr(32'h140, 32'h6);
    i_tbp_encoder.step(2, 1'b1);
    rdChk(32'h90, 32'hffff, 32'h0);
    rdChk(32'h50, 32'hffff, 32'h0);
    i_tbp_encoder.step(2, 1'b0);
    rdChk(32'h50, 32'hffff, 32'hffff);
    rdChk(32'h4c, 32'h30, 32'h30);
    $display("test cascade done");
  endtask : testCascade
  task automatic testPwm();
    int n;
    doReset();
    wr(32'h14, 32'h7);
    wr(32'h18, 32'h3);
    wr(32'h00, 32'h20);
    wr(32'h08, 32'h21);
    wr(32'h04, 32'h2);
    wr(32'h140, 32'h1);
    cntHigh(0, n);
    `CHK(n, 4)
    wr(32'h18, 32'h7);
    cntHigh(0, n);
    `CHK(n % 8, 0)
    doReset();
    wr(32'h14, 32'h2);
    wr(32'h18, 32'h7);
    wr(32'h00, 32'h40);
    wr(32'h08, 32'h42);
    wr(32'h04, 32'h3);
    wr(32'h140, 32'h1);
    cntHigh(0, n);
    `CHK(n, 5)
    cntHigh(1, n);
    `CHK(n, 8)
    wr(32'h14, 32'h7);
    cntHigh(0, n);
    `CHK(n, 0)
    $display("test pwm done");
  endtask : testPwm
  task automatic testCapture();
    logic [31:0] q;
    doReset();
    wr(32'hc8, 32'h80);
    wr(32'hc4, 32'h20);
    wr(32'h140, 32'h8);
    `CHK(ioPinOeN[13], 1'b1)
    ioPinIn[13] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdChk(32'he0, 32'hffff, 32'hffff);
    bus(1'b0, 32'hd8, 32'h0, q);
    `CHK(q[15:8], 8'h00)
    ioPinIn[13] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    ioPinIn[13] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdChk(32'he0, 32'hffff, q & 32'hffff);
    $display("test capture done");
  endtask : testCapture
  initial
  begin
    testRefuse();
    testBuffer();
    testPhase();
    testCascade();
    testPwm();
    testCapture();
    complete_run();
  end
endmodule : test_timer_buffer_cascade_pwm_phase
